// file: include/rsp_consts.svh
// bit-position, count and field constants for the radio config serial port
`ifndef RSP_CONSTS_SVH
`define RSP_CONSTS_SVH
`define RSP_HDR_RW_BIT    3'd7
`define RSP_HDR_BURST_BIT 3'd6
`define RSP_HDR_ADDR_HI   5
`define RSP_ST_RDY_BIT    3'd7
`define RSP_BYTE_LAST     3'h7
`define RSP_FIFO_SAT      7'h0F
`define RSP_SYNC_RST      2'h0
`endif

// file: include/rsp_pkg.sv
// types for the radio config serial port
package rsp_pkg;
  typedef enum logic [2:0] {
    RSP_MS_IDLE      = 3'b000,
    RSP_MS_RX        = 3'b001,
    RSP_MS_TX        = 3'b010,
    RSP_MS_FSTX      = 3'b011,
    RSP_MS_CAL       = 3'b100,
    RSP_MS_SETTLE    = 3'b101
  } rsp_main_state_t;

  typedef enum logic [1:0] {
    RSP_PH_OFF  = 2'b00,
    RSP_PH_WAIT = 2'b01,
    RSP_PH_HDR  = 2'b10,
    RSP_PH_DATA = 2'b11
  } rsp_phase_t;
endpackage

// file: logic/rsp_port.sv
// serial configuration port slave of the radio device
// Functional notes
// R1 - Every byte on the serial link moves most significant bit first.
// R2 - Each transaction opens with a header of read/write flag, burst flag and 6-bit address.
// R3 - The host holds chip select low from the header through the last data byte.
// R4 - Chip select rising mid-header or mid-data abandons the transfer with no partial effect.
// R5 - The host waits for the serial output to read low before clocking the header.
// R6 - The serial output stays high after select until the oscillator runs, then goes low.
// R7 - Outside sleep or oscillator-off the serial output goes low at once after select.
// R8 - During each incoming byte a status byte goes out whose bit 7 is the not-ready flag; the code sends readData instead during read data bytes.
// R9 - Status bits 6:4 report the main state code.
// R10 - Status bits 3:0 give readable or free buffer bytes, saturating at 15.
// R11 - Header read/write flag 1 means read and 0 means write.
// R12 - Header bit 7 is read/write, bit 6 burst, bits 5:0 the address.
`include "rsp_consts.svh"
module rsp_port
  import rsp_pkg::*;
#(
  parameter int ADDR_W  = 6,
  parameter int FIFO_W  = 7
) (
  input  wire logic                  sys_clk,           // system clock
  input  wire logic                  arst_n,            // async reset, active low
  input  wire logic                  serialClk,         // host serial clock pin
  input  wire logic                  chipSelectLow_n,   // chip select pin, active low
  input  wire logic                  serialIn,          // host to device data pin
  output logic                       serialOut,         // device to host data pin
  output logic                       serialOutEn_n,     // output enable, low drives
  input  wire logic                  oscillatorRunning, // crystal stable
  input  wire logic                  oscillatorOffState,// sleep or oscillator-off
  input  wire logic [2:0]            mainState,         // main state code
  input  wire logic [FIFO_W-1:0]     rxBytesAvail,      // readable receive bytes
  input  wire logic [FIFO_W-1:0]     txBytesFree,       // free transmit bytes
  input  wire logic [7:0]            readData,          // data for the addressed location
  output logic                       hdrValid,          // pulse: header taken
  output logic                       hdrRead,           // header read flag
  output logic                       hdrBurst,          // header burst flag
  output logic [ADDR_W-1:0]          registerAddressField, // header address
  output logic                       wrValid,           // pulse: whole data byte written
  output logic [7:0]                 wrData,            // written byte
  output logic                       rdTaken,           // pulse: read byte completed
  output logic                       xferAbort          // pulse: transfer cancelled
);
  typedef struct packed {
    rsp_phase_t         phase;
    logic [2:0]         bitCnt;
    logic [7:0]         shIn;
    logic [7:0]         shOut;
    logic               outBit;
    logic               rdMode;
    logic               hdrValid;
    logic               hdrRead;
    logic               hdrBurst;
    logic [ADDR_W-1:0]  addr;
    logic               wrValid;
    logic [7:0]         wrData;
    logic               rdTaken;
    logic               abort;
  } rsp_port_state_t;

  rsp_port_state_t s_q;
  rsp_port_state_t s_d;

  logic sclkLvl, sclkRise, sclkFall;
  logic csLvl, csRise, csFall;
  logic siLvl;

  rsp_sync u_sclk (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .asyncIn (serialClk),
    .syncOut (sclkLvl),
    .rise    (sclkRise),
    .fall    (sclkFall)
  );
  rsp_sync #(
    .IDLE_LVL (1'b1)
  ) u_cs (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .asyncIn (chipSelectLow_n),
    .syncOut (csLvl),
    .rise    (csRise),
    .fall    (csFall)
  );
  rsp_sync u_si (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .asyncIn (serialIn),
    .syncOut (siLvl),
    .rise    (),
    .fall    ()
  );

  logic       oscOk;
  logic [3:0] availSat;
  logic [3:0] rxSat;
  logic [3:0] txSat;
  logic [7:0] statusByte;
  logic [7:0] inByte;

  always_comb begin
    oscOk    = oscillatorRunning & ~oscillatorOffState;
    rxSat    = (rxBytesAvail >= FIFO_W'(`RSP_FIFO_SAT)) ? 4'hF : rxBytesAvail[3:0]; // [R10]
    txSat    = (txBytesFree >= FIFO_W'(`RSP_FIFO_SAT)) ? 4'hF : txBytesFree[3:0];   // [R10]
    availSat = s_q.rdMode ? rxSat : txSat;                         // [R10] [R11]
    statusByte = {~oscOk, mainState, availSat};                    // [R8] [R9]
    inByte   = {s_q.shIn[6:0], siLvl};                             // [R1]
  end

  always_comb begin
    s_d          = s_q;
    s_d.hdrValid = 1'b0;
    s_d.wrValid  = 1'b0;
    s_d.rdTaken  = 1'b0;
    s_d.abort    = 1'b0;
    if (csLvl) begin
      // deselected: drop phase and bit count, header fields held, nothing half-done is applied
      if (s_q.phase == RSP_PH_HDR || s_q.phase == RSP_PH_DATA) begin
        s_d.abort = (s_q.bitCnt != 3'h0);                          // [R4]
      end
      s_d.phase  = RSP_PH_OFF;
      s_d.bitCnt = 3'h0;
      s_d.outBit = 1'b1;
    end else begin
      case (s_q.phase)
        RSP_PH_OFF: begin
          s_d.phase  = RSP_PH_WAIT;
          s_d.rdMode = 1'b0;
          s_d.outBit = 1'b1;
        end
        RSP_PH_WAIT: begin
          // line stays high until the crystal runs
          s_d.outBit = ~oscOk;                                     // [R6] [R7]
          if (oscOk) begin
            s_d.phase = RSP_PH_HDR;                                // [R5]
            s_d.shOut = statusByte;
          end
        end
        RSP_PH_HDR, RSP_PH_DATA: begin
          if (s_q.bitCnt == 3'h0 && !sclkLvl) begin
            s_d.outBit = s_q.shOut[`RSP_ST_RDY_BIT];               // [R8]
          end
          if (sclkRise) begin
            s_d.shIn   = inByte;                                   // [R1]
            s_d.bitCnt = s_q.bitCnt + 3'h1;
            if (s_q.phase == RSP_PH_HDR && s_q.bitCnt == 3'h0) begin
              // first header bit is the read flag: pick the count sent in 3:0
              s_d.rdMode     = siLvl;                              // [R10] [R11]
              s_d.shOut[3:0] = siLvl ? rxSat : txSat;              // [R10]
            end
            if (s_q.bitCnt == `RSP_BYTE_LAST) begin
              if (s_q.phase == RSP_PH_HDR) begin
                s_d.hdrValid = 1'b1;                               // [R2]
                s_d.hdrRead  = inByte[`RSP_HDR_RW_BIT];            // [R11] [R12]
                s_d.hdrBurst = inByte[`RSP_HDR_BURST_BIT];         // [R12]
                s_d.addr     = inByte[`RSP_HDR_ADDR_HI:0];         // [R12]
                s_d.rdMode   = inByte[`RSP_HDR_RW_BIT];
                s_d.phase    = RSP_PH_DATA;
              end else begin
                if (s_q.hdrRead) begin
                  s_d.rdTaken = 1'b1;
                end else begin
                  s_d.wrValid = 1'b1;                              // [R4]
                  s_d.wrData  = inByte;
                end
                if (!s_q.hdrBurst) begin
                  s_d.phase = RSP_PH_HDR;
                end else begin
                  s_d.addr = s_q.addr + ADDR_W'(1);
                end
              end
            end
          end
          if (sclkFall) begin
            if (s_q.bitCnt == 3'h0) begin
              // next byte: read data in data phase of a read, else status
              s_d.shOut = (s_q.phase == RSP_PH_DATA && s_q.hdrRead) ? readData
                                                                    : statusByte;
              s_d.outBit = (s_q.phase == RSP_PH_DATA && s_q.hdrRead) ?
                           readData[`RSP_ST_RDY_BIT] : statusByte[`RSP_ST_RDY_BIT];
            end else begin
              s_d.shOut  = {s_q.shOut[6:0], 1'b0};                 // [R1]
              s_d.outBit = s_q.shOut[6];
            end
          end
        end
        default: begin
          s_d.phase = RSP_PH_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '{phase: RSP_PH_OFF, outBit: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign serialOut            = s_q.outBit;
  assign serialOutEn_n        = (s_q.phase == RSP_PH_OFF);
  assign hdrValid             = s_q.hdrValid;
  assign hdrRead              = s_q.hdrRead;
  assign hdrBurst             = s_q.hdrBurst;
  assign registerAddressField = s_q.addr;
  assign wrValid              = s_q.wrValid;
  assign wrData               = s_q.wrData;
  assign rdTaken              = s_q.rdTaken;
  assign xferAbort            = s_q.abort;
endmodule

// file: logic/rsp_sync.sv
// two-stage synchroniser with edge detection on the settled value
`include "rsp_consts.svh"
module rsp_sync
  import rsp_pkg::*;
#(
  parameter logic IDLE_LVL = 1'b0  // pin level while the link is idle
) (
  input  wire logic sys_clk,   // system clock
  input  wire logic arst_n,    // async reset, active low
  input  wire logic asyncIn,   // pin level
  output logic      syncOut,   // settled level
  output logic      rise,      // one-cycle rising edge pulse
  output logic      fall       // one-cycle falling edge pulse
);
  typedef struct packed {
    logic [1:0] stage;
    logic       prev;
  } rsp_sync_state_t;

  rsp_sync_state_t s_q;
  rsp_sync_state_t s_d;

  always_comb begin
    s_d       = s_q;
    s_d.stage = {s_q.stage[0], asyncIn};
    s_d.prev  = s_q.stage[1];
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      // start at the idle level so no false edge or select follows reset
      s_q <= '{stage: {2{IDLE_LVL}}, prev: IDLE_LVL};
    end else begin
      s_q <= s_d;
    end
  end

  assign syncOut = s_q.stage[1];
  assign rise    = s_q.stage[1] & ~s_q.prev;
  assign fall    = ~s_q.stage[1] & s_q.prev;
endmodule

// file: test/rsp_host_model.sv
// host serial master driving the configuration port
module rsp_host_model (
  input wire logic sys_clk,         // system clock
  input wire logic serialOut,       // device data pin
  output logic     serialClk,       // serial clock, idle low
  output logic     chipSelectLow_n, // chip select, active low
  output logic     serialIn,        // host data pin
  output logic [7:0] statusSeen     // last eight bits shifted in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {serialClk, chipSelectLow_n, serialIn, statusSeen} = {3'b010, 8'h00};
  task automatic half();
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic shift(input logic [7:0] b, input int nBits);
    for (int i = 7; i > 7 - nBits; i--) begin
      serialIn <= b[i];
      half();
      serialClk <= 1'b1;
      statusSeen <= {statusSeen[6:0], serialOut};
      half();
      serialClk <= 1'b0;
    end
  endtask
  task automatic frame(input logic [7:0] hdr, dat, input int cut, output logic ok);
    int n;
    @(posedge sys_clk);
    chipSelectLow_n <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (serialOut !== 1'b0 && n < 300);
    ok = (n < 300);
    if (ok) shift(hdr, cut > 8 ? 8 : cut);
    if (ok && cut > 8) shift(dat, cut - 8);
    half();
    chipSelectLow_n <= 1'b1;
    serialIn <= ~serialIn;
  endtask
endmodule

// file: test/rsp_port_monitor.sv
// assertion checker for the serial configuration port
module rsp_port_monitor
  import rsp_pkg::*;
#(
  parameter int ADDR_W = 6
) (
  input wire logic              sys_clk,              // system clock
  input wire logic              arst_n,               // async reset, active low
  input wire logic              chipSelectLow_n,      // chip select pin
  input wire logic              oscillatorRunning,    // crystal stable
  input wire logic              oscillatorOffState,   // sleep or oscillator-off
  input wire logic              serialOut,            // device data pin
  input wire logic              serialOutEn_n,        // output enable, low drives
  input wire logic              hdrValid,             // header pulse
  input wire logic              hdrRead,              // header read flag
  input wire logic              hdrBurst,             // header burst flag
  input wire logic [ADDR_W-1:0] registerAddressField, // header address
  input wire logic              wrValid,              // write pulse
  input wire logic              rdTaken,              // read pulse
  input wire logic              xferAbort             // abort pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence deselected;
    chipSelectLow_n [*7];
  endsequence
  sequence quickSelect;
    $fell(chipSelectLow_n) && oscillatorRunning && !oscillatorOffState;
  endsequence
  chk_idle_released: assert property (deselected |-> serialOutEn_n && serialOut)
    else $error("serial output driven while deselected");
  chk_select_ready: assert property (quickSelect |-> ##[1:8] (!serialOut && !serialOutEn_n))
    else $error("serial output not low soon after select");
  chk_hdr_spacing: assert property (hdrValid |=> (!hdrValid && !wrValid && !rdTaken) [*8])
    else $error("pulse too soon after header");
  chk_wr_spacing: assert property (wrValid |=> (!wrValid && !hdrValid) [*8])
    else $error("pulse too soon after write");
  chk_fields_hold: assert property (hdrValid |=> $stable({hdrRead, hdrBurst, registerAddressField}) [*8])
    else $error("header fields moved");
  chk_write_flag: assert property (wrValid |-> !hdrRead)
    else $error("write on read header");
  chk_read_flag: assert property (rdTaken |-> hdrRead)
    else $error("read on write header");
  chk_abort_clean: assert property (xferAbort |-> (!wrValid && !hdrValid) [*8])
    else $error("partial effect after abort");
  chk_abort_cause: assert property (xferAbort |-> chipSelectLow_n && $past(chipSelectLow_n, 2))
    else $error("abort without deselect");
  chk_hdr_selected: assert property (hdrValid |-> !serialOutEn_n)
    else $error("header taken while not selected");
endmodule
bind rsp_port rsp_port_monitor #(.ADDR_W(ADDR_W)) rsp_port_monitor_inst (
  .sys_clk(sys_clk), .arst_n(arst_n), .chipSelectLow_n(chipSelectLow_n),
  .oscillatorRunning(oscillatorRunning), .oscillatorOffState(oscillatorOffState),
  .serialOut(serialOut), .serialOutEn_n(serialOutEn_n), .hdrValid(hdrValid),
  .hdrRead(hdrRead), .hdrBurst(hdrBurst), .registerAddressField(registerAddressField),
  .wrValid(wrValid), .rdTaken(rdTaken), .xferAbort(xferAbort));

// file: test/test_radio_spi_config_port.sv
// self-checking bench for the serial configuration port
module test_radio_spi_config_port;
  import rsp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic       sys_clk = 0, arst_n = 0, oscRun = 1, oscOff = 0, ok;
  logic [2:0] mainState = 3'h0;
  logic [6:0] cnt = 7'h00, cntTx = 7'h00;
  logic [7:0] readData = 8'h00, hdrSeen, wrSeen, statusSeen, nH = 0, nW = 0, nR = 0, nA = 0;
  logic [7:0] h0, w0, r0, a0;
  logic       serialClk, csLow_n, serialIn, serialOut, soEn_n, hdrValid, hdrRead, hdrBurst;
  logic       wrValid, rdTaken, xferAbort;
  logic [5:0] addr;
  logic [7:0] wrData;
  wire        soPin = soEn_n ? 1'b1 : serialOut; // pulled-up line while released
  int         err_count = 0, checked = 0, cyc = 0;
  logic [7:0] rows [6][5] = '{'{8'h05, 8'hA5, 8'h00, 8'h03, 8'h03},
    '{8'h7F, 8'h3C, 8'h01, 8'h0F, 8'h1F}, '{8'h00, 8'hFF, 8'h02, 8'h64, 8'h2F},
    '{8'hC1, 8'h96, 8'h03, 8'h20, 8'h96}, '{8'h80, 8'h69, 8'h04, 8'h01, 8'h69},
    '{8'h2A, 8'h5A, 8'h05, 8'h0E, 8'h5E}};
  always #50 sys_clk = ~sys_clk;
  rsp_port rsp_port_inst (.sys_clk(sys_clk), .arst_n(arst_n), .serialClk(serialClk),
    .chipSelectLow_n(csLow_n), .serialIn(serialIn), .serialOut(serialOut),
    .serialOutEn_n(soEn_n), .oscillatorRunning(oscRun), .oscillatorOffState(oscOff),
    .mainState(mainState), .rxBytesAvail(cnt), .txBytesFree(cntTx), .readData(readData),
    .hdrValid(hdrValid), .hdrRead(hdrRead), .hdrBurst(hdrBurst),
    .registerAddressField(addr), .wrValid(wrValid), .wrData(wrData), .rdTaken(rdTaken),
    .xferAbort(xferAbort));
  rsp_host_model rsp_host_model_inst (.sys_clk(sys_clk), .serialOut(soPin),
    .serialClk(serialClk), .chipSelectLow_n(csLow_n), .serialIn(serialIn),
    .statusSeen(statusSeen));
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (hdrValid === 1'b1) {nH, hdrSeen} <= {nH + 8'h01, hdrRead, hdrBurst, addr};
    if (wrValid === 1'b1) {nW, wrSeen} <= {nW + 8'h01, wrData};
    if (rdTaken === 1'b1) nR <= nR + 8'h01;
    if (xferAbort === 1'b1) nA <= nA + 8'h01;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic run(input logic [7:0] hdr, dat, input int cut);
    {h0, w0, r0, a0} = {nH, nW, nR, nA};
    rsp_host_model_inst.frame(hdr, dat, cut, ok);
    repeat (10) @(posedge sys_clk);
    check({7'h00, ok}, 8'h01);
  endtask
  task automatic tally_and_finish();
    $display("errors %0d, checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    check({7'h00, serialOut}, 8'h01);
    check({7'h00, soEn_n}, 8'h01);
    arst_n <= 1'b1;
    foreach (rows[i]) begin
      {mainState, cnt, cntTx, readData} <=
        {rows[i][2][2:0], rows[i][3][6:0], rows[i][3][6:0], rows[i][1]};
      run(rows[i][0], rows[i][1], 16);
      check(hdrSeen, rows[i][0]);
      check(nH - h0, 8'h01);
      check(statusSeen, rows[i][4]);
      check(rows[i][0][7] ? nR - r0 : nW - w0, 8'h01);
      if (!rows[i][0][7]) check(wrSeen, rows[i][1]);
      if (rows[i][0][6]) check(addr, 6'(rows[i][0][5:0] + 6'h01));
    end
    {mainState, cnt, cntTx} <= {3'h3, 7'h09, 7'h02};
    run(8'hB0, 8'h00, 8);
    check(statusSeen, 8'h39);
    run(8'h30, 8'h00, 8);
    check(statusSeen, 8'h32);
    run(8'h12, 8'hFF, 12);
    check({nA - a0, nW - w0, nH - h0}, {8'h01, 8'h00, 8'h01});
    run(8'h12, 8'hFF, 5);
    check({nA - a0, nH - h0}, {8'h01, 8'h00});
    {oscRun, oscOff} <= 2'b01;
    fork
      run(8'h09, 8'h44, 16);
      begin
        repeat (40) @(posedge sys_clk);
        check({7'h00, serialOut}, 8'h01);
        {oscRun, oscOff} <= 2'b10;
      end
    join
    check({nW - w0, wrSeen}, {8'h01, 8'h44});
    tally_and_finish();
  end
endmodule
